// ### common/cise_params.svh
// Purpose: constants for the compact integer store/alu execute block
// Assumes: included by bare name wherever the constants are needed
// Notes: instruction field positions are bit indices of the fetched word
//
// Behaviour
// - pair store: major 001000, minor 1001 at 15..12, source, base, 12-bit offset.
// - pair store address is sign-extended 12-bit offset plus base register.
// - pair stores low word of named register, then next register at plus 4.
// - second pair word is translated anew from offset plus base plus 4.
// - old mode raises address error on misaligned word; new mode may allow.
// - pair naming register 31 is undefined; software must not issue it.
// - word stores raise only refill, invalid, modified, address error, watch.
// - multiple store starts at offset plus base, one word per register, plus 4.
// - physical low bits xor swap flag; lane from virtual bits xor high-first flag.
// - list codes 1..9 select registers from 16, ninth is 30; top bit adds 31.
// - short xor: major 010001, minor 1000 in low bits, two 3-bit register fields.
// - short xor writes xor of both registers into second operand register.
// - 3-bit register fields reach only registers 2..7, 16 and 17.
// - trapping add: major 000000, bit 10 zero, minor 0100010000 at 9..0.
// - trapping add forms 33-bit sum; bit 32 differing bit 31 traps, no write.
// - non-overflowing trapping add writes sign-extended 32-bit sum.
// - sources not holding sign-extended words give unpredictable results, unchecked.
// - immediate add: major 001100, destination 25..21, source 20..16, 16-bit immediate.
// - immediate add writes sign-extended modulo sum and never traps.
// - each store goes out word-sized with cache attribute, addresses and data.
`ifndef CISE_PARAMS_SVH
`define CISE_PARAMS_SVH

`define CISE_MAJ_HI 31
`define CISE_MAJ_LO 26
`define CISE_MAJ_STORE_GROUP 6'h08
`define CISE_MAJ_ARITH_GROUP 6'h00
`define CISE_MAJ_IMM_SUM 6'h0c
`define CISE_MAJ_SHORT_LOGIC 6'h11
`define CISE_MIN_PAIR 4'h9
`define CISE_MIN_MULTI 4'hd
`define CISE_MIN_SHORT_XOR 4'h8
`define CISE_MIN_TRAP_ADD 10'h110
`define CISE_LIST_MAX 4'h9
`define CISE_LIST_FIRST_REG 5'h10
`define CISE_LIST_NINTH_REG 5'h1e
`define CISE_LINK_REG 5'h1f
`define CISE_WORD_STEP 64'h4
`define CISE_SIZE_WORD 2'h2
`define CISE_RESET_DATA 64'h0

`endif

// ### common/cise_pkg.sv
// Purpose: types shared by the compact integer store/alu execute block
// Assumes: constants come from cise_params.svh
// Notes: store request is built in one cycle and held until accepted
package cise_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XLAT = 2'b01,
    ST_ISSUE = 2'b11
  } cise_state_e;

  typedef enum logic [2:0] {
    EXC_NONE = 3'h0,
    EXC_ADDR_ERR = 3'h1,
    EXC_XLAT_REFILL = 3'h2,
    EXC_XLAT_INVALID = 3'h3,
    EXC_XLAT_MODIFIED = 3'h4,
    EXC_WATCH = 3'h5,
    EXC_OVERFLOW = 3'h6
  } cise_exc_e;

  typedef enum logic [1:0] {
    XF_NONE = 2'h0,
    XF_REFILL = 2'h1,
    XF_INVALID = 2'h2,
    XF_MODIFIED = 2'h3
  } cise_xfault_e;

  typedef struct packed {
    logic [63:0] paddr;
    logic [2:0] cacheAttribute;
    cise_xfault_e fault;
    logic watch;
  } cise_xlat_s;

  typedef struct packed {
    logic [1:0] size;
    logic [2:0] cacheAttribute;
    logic [63:0] paddr;
    logic [63:0] virtualLocation;
    logic [63:0] data;
  } cise_store_s;

endpackage

// ### hw/cise_exec.sv
// Purpose: decode and execute of pair/multiple word stores, short xor and word adds
// Assumes: one core clock; translation answers with xlatDone at least one cycle later
// Notes: general registers live here; loadEn/peek reach them from outside
`timescale 1ns/1ns
`include "cise_params.svh"
module cise_exec #(
  parameter int PA_W = 40,
  parameter bit MISALIGN_OK = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic instrShort,
  output logic instrReady,
  input wire logic preRel6Mode,
  input wire logic swappedByteOrderFlag,
  input wire logic highByteFirstFlag,
  output logic xlatValid,
  output logic [63:0] xlatVaddr,
  input wire logic xlatDone,
  input wire cise_pkg::cise_xlat_s xlatResp,
  output logic storeValid,
  input wire logic storeReady,
  output cise_pkg::cise_store_s storeReq,
  output logic excValid,
  output cise_pkg::cise_exc_e excCode,
  output logic instrDone,
  input wire logic loadEn,
  input wire logic [4:0] loadIdx,
  input wire logic [63:0] loadData,
  input wire logic [4:0] peekIdx,
  output logic [63:0] peekData
);

  generate
    if (PA_W < 3 || PA_W > 64) begin : g_bad_pa
      $error("PA_W must lie between 3 and 64");
    end
  endgenerate

  logic [63:0] gpr [32];
  cise_pkg::cise_state_e state_q;
  cise_pkg::cise_state_e state_d;
  logic [63:0] seqVaddr_q;
  logic [3:0] seqIdx_q;
  logic [3:0] seqCount_q;
  logic seqPair_q;
  logic [4:0] seqFirst_q;
  logic [4:0] seqListLow_q;
  cise_pkg::cise_store_s storeReq_q;
  logic excValid_q;
  cise_pkg::cise_exc_e excCode_q;
  logic instrDone_q;
  logic [63:0] peekData_q;

  // decode
  logic accept;
  logic isPair;
  logic isMulti;
  logic isXor;
  logic isTrapAdd;
  logic isImmSum;
  logic [5:0] longMajor;
  logic [5:0] shortMajor;
  logic [4:0] fieldHi;
  logic [4:0] fieldMid;
  logic [4:0] shortSecond;
  logic [4:0] shortPrimary;
  logic [63:0] effAddr;
  logic listOk;
  logic [3:0] listCount;
  logic alignFault;
  logic [32:0] trapSum;
  logic [31:0] immSum;
  logic [63:0] shortXor;
  logic lastStore;
  logic [4:0] curReg;
  logic [2:0] byteSel;
  logic [63:0] shiftedData;
  logic [63:0] adjPaddr;
  logic [63:0] paMask;

  // 3-bit field to register number
  function automatic logic [4:0] shortReg(input logic [2:0] code);
    logic [4:0] r;
    r = 5'h00;
    if (code == 3'h6) begin
      r = 5'h10;
    end else if (code == 3'h7) begin
      r = 5'h11;
    end else begin
      r = {2'b00, code} + 5'h02;
    end
    return r;
  endfunction

  // register of list slot, pair or multiple
  function automatic logic [4:0] slotReg(input logic pair, input logic [4:0] first,
                                         input logic [4:0] list, input logic [3:0] idx);
    logic [4:0] r;
    r = 5'h00;
    if (pair) begin
      r = first + {4'h0, idx[0]};
    end else if (idx == list[3:0]) begin
      r = `CISE_LINK_REG;
    end else if (idx == 4'h8) begin
      r = `CISE_LIST_NINTH_REG;
    end else begin
      r = `CISE_LIST_FIRST_REG + {1'b0, idx};
    end
    return r;
  endfunction

  always_comb begin
    longMajor = instrWord[`CISE_MAJ_HI:`CISE_MAJ_LO];
    shortMajor = instrWord[15:10];
    fieldHi = instrWord[25:21];
    fieldMid = instrWord[20:16];
    isPair = !instrShort && longMajor == `CISE_MAJ_STORE_GROUP
      && instrWord[15:12] == `CISE_MIN_PAIR;
    isMulti = !instrShort && longMajor == `CISE_MAJ_STORE_GROUP
      && instrWord[15:12] == `CISE_MIN_MULTI;
    isXor = instrShort && shortMajor == `CISE_MAJ_SHORT_LOGIC
      && instrWord[3:0] == `CISE_MIN_SHORT_XOR;
    isTrapAdd = !instrShort && longMajor == `CISE_MAJ_ARITH_GROUP && !instrWord[10]
      && instrWord[9:0] == `CISE_MIN_TRAP_ADD;
    isImmSum = !instrShort && longMajor == `CISE_MAJ_IMM_SUM;
    shortSecond = shortReg(instrWord[9:7]);
    shortPrimary = shortReg(instrWord[6:4]);
    // sign-extended 12-bit offset plus base
    effAddr = gpr[fieldMid] + {{52{instrWord[11]}}, instrWord[11:0]};
    listOk = fieldHi[3:0] <= `CISE_LIST_MAX && (fieldHi[3:0] != 4'h0 || fieldHi[4]);
    listCount = fieldHi[3:0] + {3'h0, fieldHi[4]};
    // misaligned words only pass when the new mode and the hardware both allow it
    alignFault = effAddr[1:0] != 2'b00 && (preRel6Mode || !MISALIGN_OK);
    // no word check on sources: ill-formed operands simply give what they give
    trapSum = {gpr[fieldMid][31], gpr[fieldMid][31:0]}
      + {gpr[fieldHi][31], gpr[fieldHi][31:0]};
    immSum = gpr[fieldMid][31:0] + {{16{instrWord[15]}}, instrWord[15:0]};
    shortXor = gpr[shortPrimary] ^ gpr[shortSecond];
  end

  assign accept = instrValid && state_q == cise_pkg::ST_IDLE;
  assign instrReady = state_q == cise_pkg::ST_IDLE;

  always_comb begin
    curReg = slotReg(seqPair_q, seqFirst_q, seqListLow_q, seqIdx_q);
    byteSel = seqVaddr_q[2:0] ^ {highByteFirstFlag, 2'b00};
    shiftedData = gpr[curReg] << {byteSel, 3'b000};
    paMask = {64{1'b1}} >> (7'd64 - 7'(PA_W));
    adjPaddr = (xlatResp.paddr & paMask)
      ^ {61'h0, swappedByteOrderFlag, 2'b00};
    lastStore = seqIdx_q + 4'h1 == seqCount_q;
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      cise_pkg::ST_IDLE: begin
        if (accept && (isPair || (isMulti && listOk)) && !alignFault) begin
          state_d = cise_pkg::ST_XLAT;
        end
      end
      cise_pkg::ST_XLAT: begin
        if (xlatDone) begin
          if (xlatResp.fault != cise_pkg::XF_NONE || xlatResp.watch) begin
            state_d = cise_pkg::ST_IDLE;
          end else begin
            state_d = cise_pkg::ST_ISSUE;
          end
        end
      end
      cise_pkg::ST_ISSUE: begin
        if (storeReady) begin
          state_d = lastStore ? cise_pkg::ST_IDLE : cise_pkg::ST_XLAT;
        end
      end
      default: begin
        state_d = cise_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= cise_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // store sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      seqVaddr_q <= `CISE_RESET_DATA;
      seqIdx_q <= 4'h0;
      seqCount_q <= 4'h0;
      seqPair_q <= 1'b0;
      seqFirst_q <= 5'h00;
      seqListLow_q <= 5'h00;
    end else if (state_q == cise_pkg::ST_IDLE && accept) begin
      seqVaddr_q <= effAddr;
      seqIdx_q <= 4'h0;
      seqPair_q <= isPair;
      // a pair naming the link register wraps to register 0; that form is not for use
      seqFirst_q <= fieldHi;
      seqListLow_q <= {1'b0, fieldHi[3:0]};
      seqCount_q <= isPair ? 4'h2 : listCount;
    end else if (state_q == cise_pkg::ST_ISSUE && storeReady && !lastStore) begin
      seqIdx_q <= seqIdx_q + 4'h1;
      // next word is translated from its own virtual address
      seqVaddr_q <= seqVaddr_q + `CISE_WORD_STEP;
    end
  end

  // store request held from translation answer until taken
  always_ff @(posedge clk) begin
    if (rst) begin
      storeReq_q <= '0;
    end else if (state_q == cise_pkg::ST_XLAT && xlatDone) begin
      storeReq_q.size <= `CISE_SIZE_WORD;
      storeReq_q.cacheAttribute <= xlatResp.cacheAttribute;
      storeReq_q.paddr <= adjPaddr;
      storeReq_q.virtualLocation <= seqVaddr_q;
      storeReq_q.data <= shiftedData;
    end
  end

  assign xlatValid = state_q == cise_pkg::ST_XLAT;
  assign xlatVaddr = seqVaddr_q;
  assign storeValid = state_q == cise_pkg::ST_ISSUE;
  assign storeReq = storeReq_q;

  // exception and completion pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      excValid_q <= 1'b0;
      excCode_q <= cise_pkg::EXC_NONE;
      instrDone_q <= 1'b0;
    end else begin
      excValid_q <= 1'b0;
      excCode_q <= cise_pkg::EXC_NONE;
      instrDone_q <= 1'b0;
      if (accept) begin
        if ((isPair || (isMulti && listOk)) && alignFault) begin
          excValid_q <= 1'b1;
          excCode_q <= cise_pkg::EXC_ADDR_ERR;
        end else if (isTrapAdd && trapSum[32] != trapSum[31]) begin
          excValid_q <= 1'b1;
          excCode_q <= cise_pkg::EXC_OVERFLOW;
        end else if (!(isPair || (isMulti && listOk))) begin
          instrDone_q <= 1'b1;
        end
      end else if (state_q == cise_pkg::ST_XLAT && xlatDone) begin
        if (xlatResp.watch) begin
          excValid_q <= 1'b1;
          excCode_q <= cise_pkg::EXC_WATCH;
        end else if (xlatResp.fault != cise_pkg::XF_NONE) begin
          excValid_q <= 1'b1;
          case (xlatResp.fault)
            cise_pkg::XF_REFILL: excCode_q <= cise_pkg::EXC_XLAT_REFILL;
            cise_pkg::XF_INVALID: excCode_q <= cise_pkg::EXC_XLAT_INVALID;
            default: excCode_q <= cise_pkg::EXC_XLAT_MODIFIED;
          endcase
        end
      end else if (state_q == cise_pkg::ST_ISSUE && storeReady && lastStore) begin
        instrDone_q <= 1'b1;
      end
    end
  end

  assign excValid = excValid_q;
  assign excCode = excCode_q;
  assign instrDone = instrDone_q;

  // general registers; register 0 stays zero, execution wins over the load port
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        gpr[i] <= `CISE_RESET_DATA;
      end
    end else if (accept && isXor) begin
      gpr[shortSecond] <= shortXor;
    end else if (accept && isTrapAdd && trapSum[32] == trapSum[31]) begin
      if (instrWord[15:11] != 5'h00) begin
        gpr[instrWord[15:11]] <= {{32{trapSum[31]}}, trapSum[31:0]};
      end
    end else if (accept && isImmSum) begin
      if (fieldHi != 5'h00) begin
        gpr[fieldHi] <= {{32{immSum[31]}}, immSum};
      end
    end else if (loadEn && loadIdx != 5'h00) begin
      gpr[loadIdx] <= loadData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      peekData_q <= `CISE_RESET_DATA;
    end else begin
      peekData_q <= gpr[peekIdx];
    end
  end

  assign peekData = peekData_q;

endmodule // cise_exec

// ### bench/cise_exec_chk.sv
// Purpose: port-level checks for cise_exec
// Assumes: sees only the top-level ports of cise_exec
// Notes: lane check trusts the high-first flag to hold while a store is busy
`timescale 1ns/1ns
`include "cise_params.svh"
module cise_exec_chk #(
  parameter int PA_W = 40
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [31:0] instrWord,
  input wire logic instrShort,
  input wire logic instrReady,
  input wire logic swappedByteOrderFlag,
  input wire logic highByteFirstFlag,
  input wire logic xlatValid,
  input wire logic [63:0] xlatVaddr,
  input wire logic xlatDone,
  input wire cise_pkg::cise_xlat_s xlatResp,
  input wire logic storeValid,
  input wire logic storeReady,
  input wire cise_pkg::cise_store_s storeReq,
  input wire logic excValid,
  input wire cise_pkg::cise_exc_e excCode,
  input wire logic instrDone
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic [5:0] laneBits = {storeReq.virtualLocation[2:0] ^ {highByteFirstFlag, 2'b00}, 3'b000};
  sequence accept_s;
    storeValid && storeReady;
  endsequence
  sequence xok_s;
    xlatValid && xlatDone && xlatResp.fault == cise_pkg::XF_NONE && !xlatResp.watch;
  endsequence
  sequence xbad_s;
    xlatValid && xlatDone && (xlatResp.fault != cise_pkg::XF_NONE || xlatResp.watch);
  endsequence
  sequence addTake_s;
    instrValid && instrReady && !instrShort && instrWord[31:26] == `CISE_MAJ_ARITH_GROUP
      && instrWord[10:0] == {1'b0, `CISE_MIN_TRAP_ADD};
  endsequence
  busy_refuse_a: assert property ((xlatValid || storeValid) |-> !instrReady)
    else $error("ready while busy");
  xlat_hold_a: assert property (xlatValid && !xlatDone |=> xlatValid && $stable(xlatVaddr))
    else $error("translation request moved");
  store_hold_a: assert property (storeValid && !storeReady |=> storeValid && $stable(storeReq))
    else $error("store request moved");
  word_size_a: assert property (storeValid |-> storeReq.size == `CISE_SIZE_WORD
    && (storeReq.paddr >> PA_W) == 64'h0) else $error("bad store size or address width");
  xlat_fwd_a: assert property (xok_s |=> storeValid
    && storeReq.cacheAttribute == $past(xlatResp.cacheAttribute)
    && storeReq.virtualLocation == $past(xlatVaddr)
    && storeReq.paddr[2:0] == ($past(xlatResp.paddr[2:0]) ^ {$past(swappedByteOrderFlag), 2'b00}))
    else $error("store does not follow translation");
  lane_shift_a: assert property (storeValid |-> (storeReq.data & ((64'h1 << laneBits) - 64'h1)) == 64'h0)
    else $error("store data not shifted to lane");
  fault_exc_a: assert property (xbad_s |=> excValid && !storeValid && excCode ==
    ($past(xlatResp.watch) ? cise_pkg::EXC_WATCH
    : cise_pkg::cise_exc_e'({1'b0, $past(xlatResp.fault)} + 3'h1))) else $error("bad fault code");
  next_word_a: assert property (accept_s ##1 xlatValid |->
    xlatVaddr == $past(storeReq.virtualLocation) + `CISE_WORD_STEP) else $error("bad next address");
  add_answer_a: assert property (addTake_s |=> (instrDone != excValid)
    && (!excValid || excCode == cise_pkg::EXC_OVERFLOW)) else $error("bad trapping add answer");
endmodule // cise_exec_chk

bind cise_exec cise_exec_chk #(.PA_W(PA_W)) u_chk (
  .clk(clk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
  .instrShort(instrShort), .instrReady(instrReady),
  .swappedByteOrderFlag(swappedByteOrderFlag), .highByteFirstFlag(highByteFirstFlag),
  .xlatValid(xlatValid), .xlatVaddr(xlatVaddr), .xlatDone(xlatDone), .xlatResp(xlatResp),
  .storeValid(storeValid), .storeReady(storeReady), .storeReq(storeReq),
  .excValid(excValid), .excCode(excCode), .instrDone(instrDone)
);

// ### bench/cise_mem_model.sv
// Purpose: translator and data memory standing behind cise_exec
// Assumes: one request at a time on each side
// Notes: answers are garbled outside xlatDone so stale values are never trusted
`timescale 1ns/1ns
module cise_mem_model #(
  parameter logic [63:0] XLAT_XOR = 64'h1000,
  parameter logic [2:0] CACHE_ATTR = 3'h5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire cise_pkg::cise_xfault_e faultSel,
  input wire logic watchSel,
  input wire logic xlatValid,
  input wire logic [63:0] xlatVaddr,
  output logic xlatDone,
  output cise_pkg::cise_xlat_s xlatResp,
  input wire logic storeValid,
  output logic storeReady
);
  logic [1:0] xWait_q;
  logic [1:0] sWait_q;
  cise_pkg::cise_xlat_s ans;
  wire logic [1:0] lat = slow ? 2'h3 : 2'h1;
  always_ff @(posedge clk) begin
    if (rst || !xlatValid || xlatDone) xWait_q <= 2'h0;
    else xWait_q <= xWait_q + 2'h1;
  end
  always_ff @(posedge clk) begin
    if (rst || !storeValid || storeReady) sWait_q <= 2'h0;
    else sWait_q <= sWait_q + 2'h1;
  end
  assign xlatDone = xlatValid && xWait_q == lat;
  assign storeReady = storeValid && sWait_q == lat;
  // each word is translated from the address shown now
  always_comb begin
    ans = '{paddr: xlatVaddr ^ XLAT_XOR, cacheAttribute: CACHE_ATTR, fault: faultSel,
      watch: watchSel};
    xlatResp = xlatDone ? ans : cise_pkg::cise_xlat_s'(~ans);
  end
endmodule // cise_mem_model

// ### bench/compact_int_store_alu_exec_test.sv
// Purpose: self-checking bench for cise_exec
// Assumes: cise_mem_model answers translations and stores
// Notes: registers are preset through loadEn and read back through peek
`timescale 1ns/1ns
`include "cise_params.svh"
module compact_int_store_alu_exec_test;
  localparam logic [63:0] XLAT_XOR = 64'h1000;
  localparam logic [2:0] CATTR = 3'h5;
  localparam logic [63:0] PMASK = 64'hff_ffff_ffff;
  localparam int LIMIT = 3000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iv = 1'b0, ish = 1'b0, store_word_pair = 1'b0, hbf = 1'b0, ldEn = 1'b0, slow = 1'b0, wSel = 1'b0;
  logic rel = 1'b1;
  logic [31:0] iw = 32'h0;
  logic [4:0] ldIdx = 5'h0, pkIdx = 5'h0;
  logic [63:0] ldData = 64'h0;
  cise_pkg::cise_xfault_e fSel = cise_pkg::XF_NONE;
  logic rdy, xv, xd, sv, sr, ev, dn;
  logic [63:0] xva, pk;
  cise_pkg::cise_xlat_s xr;
  cise_pkg::cise_store_s sq;
  cise_pkg::cise_exc_e ec;
  logic [63:0] m [32] = '{default: 64'h0};
  int err_total = 0, tests_run = 0, cycles = 0;
  cise_exec DUT (.clk(clk), .rst(rst), .instrValid(iv), .instrWord(iw), .instrShort(ish),
    .instrReady(rdy), .preRel6Mode(rel), .swappedByteOrderFlag(store_word_pair), .highByteFirstFlag(hbf),
    .xlatValid(xv), .xlatVaddr(xva), .xlatDone(xd), .xlatResp(xr), .storeValid(sv),
    .storeReady(sr), .storeReq(sq), .excValid(ev), .excCode(ec), .instrDone(dn),
    .loadEn(ldEn), .loadIdx(ldIdx), .loadData(ldData), .peekIdx(pkIdx), .peekData(pk));
  cise_mem_model #(.XLAT_XOR(XLAT_XOR), .CACHE_ATTR(CATTR)) u_mem (.clk(clk), .rst(rst),
    .slow(slow), .faultSel(fSel), .watchSel(wSel), .xlatValid(xv), .xlatVaddr(xva),
    .xlatDone(xd), .xlatResp(xr), .storeValid(sv), .storeReady(sr));
  always #25 clk = ~clk;
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic cmp64(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpe(input cise_pkg::cise_exc_e got, input cise_pkg::cise_exc_e exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [4:0] rm(input logic [2:0] c);
    return (c < 3'h6) ? 5'(c) + 5'h2 : 5'(c) + 5'ha;
  endfunction
  task automatic ld(input logic [4:0] r, input logic [63:0] v);
    @(posedge clk);
    ldEn <= 1'b1;
    ldIdx <= r;
    ldData <= v;
    @(posedge clk);
    ldEn <= 1'b0;
    m[r] = v;
  endtask
  task automatic peek(input logic [4:0] r);
    @(posedge clk);
    pkIdx <= r;
    @(posedge clk);
    @(negedge clk);
    cmp64(pk, m[r]);
  endtask
  task automatic issue(input logic [31:0] w, input logic s);
    @(posedge clk);
    iv <= 1'b1;
    iw <= w;
    ish <= s;
    @(posedge clk);
    iv <= 1'b0;
  endtask
  // ends on instrDone or excValid; the code 7 stands for no answer at all
  task automatic wait_end(input cise_pkg::cise_exc_e exp);
    cise_pkg::cise_exc_e got;
    got = cise_pkg::cise_exc_e'(3'h7);
    for (int i = 0; i < 8 && got === cise_pkg::cise_exc_e'(3'h7); i++) begin
      @(negedge clk);
      if (ev === 1'b1) got = ec;
      else if (dn === 1'b1) got = cise_pkg::EXC_NONE;
    end
    cmpe(got, exp);
  endtask
  task automatic st_chk(input logic [63:0] va, input logic [4:0] r);
    logic [2:0] ln;
    logic ok;
    ln = va[2:0] ^ {hbf, 2'b00};
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge clk);
      ok = (sv === 1'b1 && sr === 1'b1);
    end
    cmp64(64'(ok), 64'h1);
    cmp64(sq.virtualLocation, va);
    cmp64(sq.paddr, ((va ^ XLAT_XOR) & PMASK) ^ 64'({store_word_pair, 2'b00}));
    cmp64(sq.data, m[r] << {ln, 3'b000});
    cmp64(64'({sq.size, sq.cacheAttribute}), 64'({`CISE_SIZE_WORD, CATTR}));
    @(posedge clk);
  endtask
  task automatic stores(input logic [4:0] lst, input logic [3:0] mn, input logic [11:0] off,
      input int n);
    logic [63:0] ea;
    logic [4:0] r;
    ea = m[24] + {{52{off[11]}}, off};
    issue({`CISE_MAJ_STORE_GROUP, lst, 5'd24, mn, off}, 1'b0);
    for (int i = 0; i < n; i++) begin
      if (mn == `CISE_MIN_PAIR) r = lst + 5'(i);
      else if (i == n - 1 && lst[4]) r = `CISE_LINK_REG;
      else r = (i == 8) ? `CISE_LIST_NINTH_REG : `CISE_LIST_FIRST_REG + 5'(i);
      st_chk(ea + 64'(4 * i), r);
    end
    wait_end(cise_pkg::EXC_NONE);
  endtask
  task automatic add_chk(input logic [4:0] rd, input logic [4:0] rs, input logic [4:0] rt);
    logic [32:0] s;
    s = {m[rs][31], m[rs][31:0]} + {m[rt][31], m[rt][31:0]};
    issue({`CISE_MAJ_ARITH_GROUP, rt, rs, rd, 1'b0, `CISE_MIN_TRAP_ADD}, 1'b0);
    if (s[32] == s[31]) m[rd] = {{32{s[31]}}, s[31:0]};
    wait_end(s[32] != s[31] ? cise_pkg::EXC_OVERFLOW : cise_pkg::EXC_NONE);
    peek(rd);
  endtask
  task automatic imm_chk(input logic [4:0] rt, input logic [4:0] rs, input logic [15:0] imm);
    logic [31:0] s;
    s = m[rs][31:0] + {{16{imm[15]}}, imm};
    issue({`CISE_MAJ_IMM_SUM, rt, rs, imm}, 1'b0);
    m[rt] = {{32{s[31]}}, s};
    wait_end(cise_pkg::EXC_NONE);
    peek(rt);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int r = 1; r < 32; r++) ld(5'(r), {32'h13570000 | 32'(r), 32'h86420000 | 32'(r)});
    for (int c = 0; c < 8; c++) begin
      issue({16'h0, `CISE_MAJ_SHORT_LOGIC, 3'(c), 3'(c + 3), `CISE_MIN_SHORT_XOR}, 1'b1);
      m[rm(3'(c))] = m[rm(3'(c))] ^ m[rm(3'(c + 3))];
      wait_end(cise_pkg::EXC_NONE);
      peek(rm(3'(c)));
    end
    ld(5'd8, 64'h7fffffff);
    ld(5'd9, 64'h1);
    ld(5'd10, 64'hffffffff_fffffffe);
    add_chk(5'd11, 5'd8, 5'd9);
    add_chk(5'd11, 5'd10, 5'd9);
    add_chk(5'd12, 5'd8, 5'd10);
    imm_chk(5'd13, 5'd8, 16'h0001);
    imm_chk(5'd14, 5'd0, 16'h8000);
    ld(5'd24, 64'h2008);
    @(posedge clk);
    store_word_pair <= 1'b1;
    hbf <= 1'b1;
    stores(5'd16, `CISE_MIN_PAIR, 12'hffc, 2);
    @(posedge clk);
    store_word_pair <= 1'b0;
    hbf <= 1'b0;
    slow <= 1'b1;
    stores(5'h19, `CISE_MIN_MULTI, 12'h010, 10);
    stores(5'h10, `CISE_MIN_MULTI, 12'h000, 1);
    issue({`CISE_MAJ_STORE_GROUP, 5'h0a, 5'd24, `CISE_MIN_MULTI, 12'h0}, 1'b0);
    wait_end(cise_pkg::EXC_NONE);
    issue({`CISE_MAJ_STORE_GROUP, 5'd16, 5'd24, `CISE_MIN_PAIR, 12'h002}, 1'b0);
    wait_end(cise_pkg::EXC_ADDR_ERR);
    // new mode without misaligned support must still refuse an odd address
    @(posedge clk);
    rel <= 1'b0;
    issue({`CISE_MAJ_STORE_GROUP, 5'd16, 5'd24, `CISE_MIN_PAIR, 12'h001}, 1'b0);
    wait_end(cise_pkg::EXC_ADDR_ERR);
    @(posedge clk);
    rel <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      fSel <= (k == 3) ? cise_pkg::XF_INVALID : cise_pkg::cise_xfault_e'(k + 1);
      wSel <= (k == 3);
      issue({`CISE_MAJ_STORE_GROUP, 5'd16, 5'd24, `CISE_MIN_PAIR, 12'h0}, 1'b0);
      wait_end((k == 3) ? cise_pkg::EXC_WATCH : cise_pkg::cise_exc_e'(k + 2));
    end
    tally_and_finish();
  end
endmodule // compact_int_store_alu_exec_test
